// >>> hw/ipc_pkg.sv
// package of the input priority configuration bank
// assumes an apb slave with 32-bit data, one register per aligned word
package ipc_pkg;
	// -------------------------------------------------------------
	// register map (word indices, byte address shifted right by IDX_LSB)
	// -------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_FIVE_SIX_IDX = 12'h01a;
	localparam logic [ADDR_W-1:0] REG_SEVEN_EIGHT_IDX = 12'h01b;
	localparam logic [ADDR_W-1:0] REG_SOURCE_SELECT_IDX = 12'h04b;
	localparam int IDX_LSB = 2;
	// -------------------------------------------------------------
	// fields and reset values
	// -------------------------------------------------------------
	localparam int PRIO_W = 4;
	localparam int NUM_INPUTS = 4;
	localparam int NUM_PATHS = 2;
	localparam int PATH_SEL_BIT = 4;
	localparam logic [7:0] FIVE_SIX_RST = 8'h76;
	localparam logic [7:0] SEVEN_EIGHT_RST = 8'h98;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 4'h0;
	localparam logic [1:0] PATH_PRIMARY = 2'h0;
	localparam logic [1:0] PATH_AUX = 2'h1;
	typedef logic [PRIO_W-1:0] ipc_prio_t;
endpackage : ipc_pkg

// >>> hw/ipc_regs_if.sv
// interface between the bank's bus decoder and its storage
// assumes one clock shared by all users
interface ipc_regs_if;
	logic wr_five_six;
	logic wr_seven_eight;
	logic bank_sel;
	logic [7:0] wdata;
	logic [7:0] rd_five_six;
	logic [7:0] rd_seven_eight;
	logic [15:0] prim_codes;
	logic [15:0] aux_codes;
	modport ctrl (output wr_five_six, output wr_seven_eight,
		output bank_sel, output wdata, input rd_five_six,
		input rd_seven_eight, input prim_codes, input aux_codes);
	modport store (input wr_five_six, input wr_seven_eight,
		input bank_sel, input wdata, output rd_five_six,
		output rd_seven_eight, output prim_codes, output aux_codes);
endinterface : ipc_regs_if

// >>> hw/ipc_store.sv
// banked storage of the priority codes, one copy per timing path
// assumes write strobes are already qualified by the bus handshake
module ipc_store
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	ipc_regs_if.store rif
);
	logic [7:0] five_six_q [ipc_pkg::NUM_PATHS];
	logic [7:0] seven_eight_q [ipc_pkg::NUM_PATHS];

	// -------------------------------------------------------------
	// per-path copies
	// -------------------------------------------------------------
	for (genvar p = 0; p < ipc_pkg::NUM_PATHS; p++)
	begin : g_path
		wire logic sel = (rif.bank_sel == p[0]);
		always_ff @(posedge clk_i)
		begin
			if (!rst_n_i)
			begin
				five_six_q[p] <= ipc_pkg::FIVE_SIX_RST;
				seven_eight_q[p] <= ipc_pkg::SEVEN_EIGHT_RST;
			end
			else if (en_i)
			begin
				if (rif.wr_five_six && sel)
					five_six_q[p] <= rif.wdata;
				if (rif.wr_seven_eight && sel)
					seven_eight_q[p] <= rif.wdata;
			end
		end
	end

	assign rif.rd_five_six = five_six_q[rif.bank_sel];
	assign rif.rd_seven_eight = seven_eight_q[rif.bank_sel];
	assign rif.prim_codes = {seven_eight_q[0], five_six_q[0]};
	assign rif.aux_codes = {seven_eight_q[1], five_six_q[1]};
endmodule // ipc_store

// >>> hw/ipc_rank.sv
// picks the eligible input with the smallest non-zero priority code
// assumes codes packed as input five in bits [3:0] upward
module ipc_rank #(
	parameter int NUM = 4
)
(
	input wire logic [NUM*4-1:0] codes_i,
	output logic valid_o,
	output logic [1:0] winner_o,
	output logic [3:0] best_o
);
	logic [3:0] best [NUM+1];
	logic [1:0] idx [NUM+1];
	logic vld [NUM+1];
	assign best[0] = 4'hf;
	assign idx[0] = 2'h0;
	assign vld[0] = 1'b0;
	// -------------------------------------------------------------
	// linear compare chain, earlier input wins a tie
	// -------------------------------------------------------------
	for (genvar i = 0; i < NUM; i++)
	begin : g_cmp
		wire logic [3:0] c = codes_i[i*4 +: 4];
		wire logic elig = (c != ipc_pkg::PRIO_OFF);
		wire logic take = elig && (!vld[i] || c < best[i]);
		assign best[i+1] = take ? c : best[i];
		assign idx[i+1] = take ? i[1:0] : idx[i];
		assign vld[i+1] = vld[i] | elig;
	end
	assign valid_o = vld[NUM];
	assign winner_o = idx[NUM];
	assign best_o = vld[NUM] ? best[NUM] : ipc_pkg::PRIO_OFF;
endmodule // ipc_rank

// >>> hw/ipc_top.sv
// apb register bank of priority codes for inputs five to eight
// assumes a single apb master; zero wait states; one clock
//
// Local design decision: the APB register port.
module ipc_top
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ipc_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic PRIM_VALID_O,
	output logic [1:0] PRIM_WINNER_O,
	output logic [3:0] PRIM_CODE_O,
	output logic AUX_VALID_O,
	output logic [1:0] AUX_WINNER_O,
	output logic [3:0] AUX_CODE_O
);
	ipc_regs_if rif ();
	logic [7:0] src_sel_q;
	logic [31:0] prdata_q;

	// -------------------------------------------------------------
	// bus decode
	// -------------------------------------------------------------
	wire logic [ipc_pkg::ADDR_W-1:0] idx =
		ipc_pkg::ADDR_W'(PADDR_I >> ipc_pkg::IDX_LSB);
	wire logic access = PSEL_I && PENABLE_I && CE_I;
	wire logic wr = access && PWRITE_I && PSTRB_I[0];
	wire logic hit_56 = (idx == ipc_pkg::REG_FIVE_SIX_IDX);
	wire logic hit_78 = (idx == ipc_pkg::REG_SEVEN_EIGHT_IDX);
	wire logic hit_src = (idx == ipc_pkg::REG_SOURCE_SELECT_IDX);
	wire logic mapped = hit_56 || hit_78 || hit_src;

	assign rif.wr_five_six = wr && hit_56;
	assign rif.wr_seven_eight = wr && hit_78;
	assign rif.wdata = PWDATA_I[7:0];
	assign rif.bank_sel = src_sel_q[ipc_pkg::PATH_SEL_BIT];

	wire logic [7:0] rd_byte = hit_56 ? rif.rd_five_six :
		hit_78 ? rif.rd_seven_eight :
		hit_src ? src_sel_q : 8'h00;

	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
	assign PRDATA_O = prdata_q;

	// -------------------------------------------------------------
	// source select register and read data
	// -------------------------------------------------------------
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			src_sel_q <= 8'h00;
		else if (wr && hit_src)
			src_sel_q <= PWDATA_I[7:0];
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			prdata_q <= 32'h0000_0000;
		else if (CE_I && PSEL_I && !PENABLE_I && !PWRITE_I)
			prdata_q <= {24'h00_0000, rd_byte};
	end

	ipc_store u_store (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.en_i(CE_I),
		.rif(rif.store)
	);

	// -------------------------------------------------------------
	// automatic selection per path
	// -------------------------------------------------------------
	logic pv, av;
	logic [1:0] pw, aw;
	logic [3:0] pc, ac;
	ipc_rank #(.NUM(ipc_pkg::NUM_INPUTS)) u_rank_prim (
		.codes_i(rif.prim_codes),
		.valid_o(pv),
		.winner_o(pw),
		.best_o(pc)
	);
	ipc_rank #(.NUM(ipc_pkg::NUM_INPUTS)) u_rank_aux (
		.codes_i(rif.aux_codes),
		.valid_o(av),
		.winner_o(aw),
		.best_o(ac)
	);

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			PRIM_VALID_O <= 1'b0;
			PRIM_WINNER_O <= 2'h0;
			PRIM_CODE_O <= 4'h0;
			AUX_VALID_O <= 1'b0;
			AUX_WINNER_O <= 2'h0;
			AUX_CODE_O <= 4'h0;
		end
		else if (CE_I)
		begin
			PRIM_VALID_O <= pv;
			PRIM_WINNER_O <= pw;
			PRIM_CODE_O <= pc;
			AUX_VALID_O <= av;
			AUX_WINNER_O <= aw;
			AUX_CODE_O <= ac;
		end
	end
endmodule // ipc_top

// >>> bench/ipc_chk.sv
// port checker of the priority bank
// bound to ipc_top; a write commits at the access edge
module ipc_chk
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ipc_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PRIM_VALID_O,
	input wire logic [1:0] PRIM_WINNER_O,
	input wire logic [3:0] PRIM_CODE_O,
	input wire logic [3:0] AUX_CODE_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	logic sel_q;
	wire wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && CE_I;
	wire one = wr && PWDATA_I[3:0] == 4'h1;
	always_ff @(posedge CLK_I)
		if (!RST_N_I)
			sel_q <= 1'b0;
		else if (wr && PADDR_I == 12'h12c)
			sel_q <= PWDATA_I[4];
	sequence s_code1(bit aux);
		one && PADDR_I == 12'h06c && sel_q == aux;
	endsequence
	a_wide_read:
		assert property (PSEL_I && PENABLE_I && !PWRITE_I
			|-> PRDATA_O[31:8] == 24'h0) else $error("wide read");
	a_lowest_wins:
		assert property (s_code1(0) |=> ##1 PRIM_CODE_O == 4'h1)
			else $error("rank");
	a_zero_off:
		assert property (PRIM_VALID_O == (PRIM_CODE_O != 4'h0))
			else $error("valid");
	a_aux_route:
		assert property (s_code1(1) |=> ##1 AUX_CODE_O == 4'h1)
			else $error("route");
	a_five_low:
		assert property (one && PADDR_I == 12'h068 && !sel_q
			|=> ##1 PRIM_WINNER_O == 2'h0) else $error("lane");
	a_reset_six:
		assert property ($rose(RST_N_I) |=> PRIM_CODE_O == 4'h6
			&& AUX_CODE_O == 4'h6) else $error("reset");
	a_prim_kept:
		assert property (s_code1(1) |=> ##1 $stable(PRIM_CODE_O))
			else $error("bank");
endmodule // ipc_chk
bind ipc_top ipc_chk i_ipc_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
	.PRIM_VALID_O(PRIM_VALID_O), .PRIM_WINNER_O(PRIM_WINNER_O),
	.PRIM_CODE_O(PRIM_CODE_O), .AUX_CODE_O(AUX_CODE_O));

// >>> bench/input_priority_config_bank_test.sv
// bench of the priority bank with a reference model
// drives ipc_top over apb; enable and strobes held on
module input_priority_config_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rn = 0, ps = 0, pe = 0, pw = 0, rdy, er, pv, av;
	logic [11:0] pa = 0;
	logic [31:0] pd = 0, pr, v, seed = 32'd61606;
	logic [1:0] pwn, awn;
	logic [3:0] pc, ac;
	logic [7:0] mm [6] = '{8'h76, 8'h98, 8'h76, 8'h98, 8'h0, 8'h0};
	logic [11:0] adr [4] = '{12'h12c, 12'h068, 12'h06c, 12'h070};
	logic [19:0] dir [7] = '{20'h12c00, 20'h06831, 20'h06c01,
		20'h12c10, 20'h06c21, 20'h06800, 20'h06c00};
	int num_errors = 0, tests_run = 0, cyc = 0;
	ipc_top i_ipc_top (.CLK_I(clk), .RST_N_I(rn), .CE_I(1'b1),
		.PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pw), .PADDR_I(pa),
		.PWDATA_I(pd), .PSTRB_I(4'hf), .PRDATA_O(pr), .PREADY_O(rdy),
		.PSLVERR_O(er), .PRIM_VALID_O(pv), .PRIM_WINNER_O(pwn),
		.PRIM_CODE_O(pc), .AUX_VALID_O(av), .AUX_WINNER_O(awn),
		.AUX_CODE_O(ac));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk)
		if (++cyc == 2000)
		begin
			num_errors++;
			conclude();
		end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// smallest non-zero code wins, ties to the lower input
	function automatic logic [31:0] best(input logic [15:0] c);
		logic [6:0] b = 7'h0;
		for (int i = 3; i >= 0; i--)
			if (c[i*4+:4] != 0 && (!b[6] || c[i*4+:4] <= b[3:0]))
				b = {1'b1, 2'(i), c[i*4+:4]};
		return 32'(b);
	endfunction
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int k;
		k = a == 12'h12c ? 4 : a[11:3] != 9'h0d ? 5 : {mm[4][4], a[2]};
		@(posedge clk);
		{ps, pe, pw, pa, pd} <= {2'b10, w, a, 24'h0, d};
		@(posedge clk);
		pe <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		if (!w)
			chk(pr, {24'h0, mm[k]});
		chk(32'(er), 32'(k == 5));
		{ps, pe} <= 2'b00;
		if (w && k < 5)
			mm[k] = d;
		@(posedge clk);
		@(negedge clk);
		chk(32'({pv, pwn, pc}), best({mm[1], mm[0]}));
		chk(32'({av, awn, ac}), best({mm[3], mm[2]}));
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rn <= 1'b1;
		for (int b = 0; b < 2; b++)
			foreach (adr[i])
				xfer(i == 0, adr[i], b ? 8'h10 : 8'h00);
		$display("reset values test done");
		foreach (dir[i])
			xfer(1'b1, dir[i][19:8], dir[i][7:0]);
		$display("directed bank test done");
		repeat (60)
		begin
			v = xs();
			xfer(v[8], adr[v[1:0]], v[23:16]);
		end
		$display("random access test done");
		conclude();
	end
endmodule // input_priority_config_bank_test
